/* rtl/branch_move_decode.v */
// Branch, trap and register-copy decode and sequencing for the integer core
// Functional notes
// [RULE1] A general-to-general copy moves the source to the destination in one cycle, flags kept.
// [RULE2] Special-to-general, general-to-special and status-word copies each finish in one cycle.
// [RULE3] A non-delayed conditional branch takes two cycles when taken and one when not.
// [RULE4] The low opcode nibble of a short branch selects one of sixteen flag conditions.
// [RULE5] A taken short branch goes to its address plus 2 plus twice the signed 8-bit field.
// [RULE6] A relative call links address plus 2 and jumps by twice the signed 11-bit field plus 2.
// [RULE7] The software trap pushes status then return address, clears I and S, reads its vector.
// [RULE8] Software issues the trap exit only with S clear; it pops PC then status with flags.
// [RULE9] Delayed branches use F0 to FF, take one cycle, and a delayed call links address plus 4.
// [RULE10] The instruction after a delayed branch always executes before the transfer.
// [RULE11] Software puts only one-cycle non-branch or memory-timed instructions in a delay slot.
// [RULE12] Indirect jump and subroutine exit load PC from a register and take two cycles undelayed.
`timescale 1ns/1ns
`default_nettype none
`include "branch_move_regs.vh"
module branch_move_decode (
    // Clock and reset
    input wire CLK,
    input wire RESETN,
    // Instruction fetch
    input wire [15:0] INSN,
    input wire INSN_VALID,
    output reg FETCH_READY,
    output reg [31:0] PC,
    // Register file read values
    input wire [31:0] SOURCE_GPR_VAL,
    input wire [31:0] DEST_GPR_VAL,
    input wire [31:0] SPECIAL_REG_VAL,
    // Register file writes
    output reg GPR_WE,
    output reg [3:0] GPR_WADDR,
    output reg [31:0] GPR_WDATA,
    output reg SPECIAL_WE,
    output reg [3:0] SPECIAL_WADDR,
    output reg [31:0] SPECIAL_WDATA,
    output reg [31:0] RETURN_LINK,
    output reg [31:0] PROCESSOR_STATUS,
    // Data memory port for stack and vector
    output reg MEM_REQ,
    output reg MEM_WRITE,
    output reg [31:0] MEM_ADDR,
    output reg [31:0] MEM_WDATA,
    input wire [31:0] MEM_RDATA,
    input wire MEM_ACK,
    // Stack pointer and vector base values
    input wire [31:0] SUPERVISOR_STACK,
    input wire [31:0] VECTOR_BASE
);
    // ------------------------------------------------------------------
    // Reset release and functions
    // ------------------------------------------------------------------
    reg rst_s1_r;
    reg rst_n_r;
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    function cond_met;
        input [3:0] sel;
        input [31:0] ps;
        reg n, z, v, c;
        begin
            n = ps[`PS_N];
            z = ps[`PS_Z];
            v = ps[`PS_V];
            c = ps[`PS_C];
            case (sel[3:1])
                3'h0: cond_met = 1'b1;
                3'h1: cond_met = z;
                3'h2: cond_met = c;
                3'h3: cond_met = n;
                3'h4: cond_met = v;
                3'h5: cond_met = v ^ n;
                3'h6: cond_met = (v ^ n) | z;
                default: cond_met = c | z;
            endcase
            if (sel[0])
                cond_met = ~cond_met; // [RULE4]
        end
    endfunction

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    localparam ST_RUN = 3'h0;
    localparam ST_BUBBLE = 3'h1;
    localparam ST_PUSH_PS = 3'h2;
    localparam ST_PUSH_PC = 3'h3;
    localparam ST_VECTOR = 3'h4;
    localparam ST_POP_PC = 3'h5;
    localparam ST_POP_PS = 3'h6;

    reg [2:0] state_r;
    reg [31:0] sp_r;
    reg [31:0] ret_r;
    reg [31:0] vec_r;
    reg [31:0] slot_target_r;
    reg slot_pending_r;

    wire [7:0] opc = INSN[`OPC_MSB:`OPC_LSB];
    wire [3:0] rj = INSN[`RJ_MSB:`RJ_LSB];
    wire [3:0] ri = INSN[`RI_MSB:`RI_LSB];
    wire [31:0] short_disp = {{23{INSN[7]}}, INSN[7:0], 1'b0};
    wire [31:0] long_disp = {{20{INSN[`DISP11_MSB]}}, INSN[`DISP11_MSB:0], 1'b0};
    wire [31:0] pc_next = PC + `INSN_BYTES;
    wire [31:0] short_disp_tgt = pc_next + short_disp; // [RULE5]
    wire [31:0] long_disp_tgt = pc_next + long_disp; // [RULE6]
    wire [31:0] trap_vec = VECTOR_BASE + `VEC_TOP - {22'h0, INSN[7:0], 2'b00}; // [RULE7]

    always @(posedge CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_RUN;
            PC <= `PC_RESET;
            PROCESSOR_STATUS <= `PS_RESET;
            RETURN_LINK <= 32'h0000_0000;
            FETCH_READY <= 1'b0;
            GPR_WE <= 1'b0;
            GPR_WADDR <= 4'h0;
            GPR_WDATA <= 32'h0000_0000;
            SPECIAL_WE <= 1'b0;
            SPECIAL_WADDR <= 4'h0;
            SPECIAL_WDATA <= 32'h0000_0000;
            MEM_REQ <= 1'b0;
            MEM_WRITE <= 1'b0;
            MEM_ADDR <= 32'h0000_0000;
            MEM_WDATA <= 32'h0000_0000;
            sp_r <= 32'h0000_0000;
            ret_r <= 32'h0000_0000;
            vec_r <= 32'h0000_0000;
            slot_target_r <= 32'h0000_0000;
            slot_pending_r <= 1'b0;
        end else begin
            GPR_WE <= 1'b0;
            SPECIAL_WE <= 1'b0;
            FETCH_READY <= 1'b0;
            case (state_r)
                ST_RUN: begin
                    FETCH_READY <= 1'b1;
                    if (INSN_VALID && FETCH_READY) begin
                        PC <= pc_next;
                        // Slot instruction runs first; then the branch lands
                        if (slot_pending_r) begin
                            PC <= slot_target_r; // [RULE10]
                            slot_pending_r <= 1'b0;
                        end
                        if (opc == `OP_COPY_GG) begin
                            GPR_WE <= 1'b1; // [RULE1]
                            GPR_WADDR <= ri;
                            GPR_WDATA <= SOURCE_GPR_VAL;
                        end else if (opc == `OP_COPY_SG) begin
                            GPR_WE <= 1'b1; // [RULE2]
                            GPR_WADDR <= ri;
                            GPR_WDATA <= SPECIAL_REG_VAL;
                        end else if (opc == `OP_COPY_GS) begin
                            SPECIAL_WE <= 1'b1; // [RULE2]
                            SPECIAL_WADDR <= rj;
                            SPECIAL_WDATA <= DEST_GPR_VAL;
                        end else if (opc == `OP_GRP17 && rj == `SUB_PS) begin
                            GPR_WE <= 1'b1; // [RULE2]
                            GPR_WADDR <= ri;
                            GPR_WDATA <= PROCESSOR_STATUS;
                        end else if (opc == `OP_GRP07 && rj == `SUB_PS) begin
                            PROCESSOR_STATUS <= DEST_GPR_VAL; // [RULE2]
                        end else if (opc[7:4] == `OP_BR_HI) begin
                            if (cond_met(opc[3:0], PROCESSOR_STATUS)) begin
                                PC <= short_disp_tgt; // [RULE3]
                                FETCH_READY <= 1'b0;
                                state_r <= ST_BUBBLE;
                            end
                        end else if ({opc[7:3], 3'b000} == `OP_CALL_REL) begin
                            // Opcode bits 2:0 are the top of the 11-bit displacement
                            RETURN_LINK <= pc_next; // [RULE6]
                            PC <= long_disp_tgt;
                            FETCH_READY <= 1'b0;
                            state_r <= ST_BUBBLE;
                        end else if (opc == `OP_GRP97 && rj <= `SUB_RET) begin
                            if (rj == `SUB_CALL)
                                RETURN_LINK <= pc_next;
                            PC <= (rj == `SUB_RET) ? RETURN_LINK : DEST_GPR_VAL; // [RULE12]
                            FETCH_READY <= 1'b0;
                            state_r <= ST_BUBBLE;
                        end else if (opc == `OP_GRP97 && rj == `SUB_TRAP_EXIT) begin
                            // Only legal with S clear, so the pop uses register 15 [RULE8]
                            FETCH_READY <= 1'b0;
                            MEM_REQ <= 1'b1;
                            MEM_WRITE <= 1'b0;
                            MEM_ADDR <= SUPERVISOR_STACK;
                            sp_r <= SUPERVISOR_STACK;
                            state_r <= ST_POP_PC;
                        end else if (opc == `OP_TRAP) begin
                            FETCH_READY <= 1'b0;
                            sp_r <= SUPERVISOR_STACK - `STACK_STEP;
                            ret_r <= pc_next;
                            vec_r <= trap_vec;
                            MEM_REQ <= 1'b1; // [RULE7]
                            MEM_WRITE <= 1'b1;
                            MEM_ADDR <= SUPERVISOR_STACK - `STACK_STEP;
                            MEM_WDATA <= PROCESSOR_STATUS;
                            state_r <= ST_PUSH_PS;
                        end else if (opc[7:4] == `OP_BRD_HI ||
                                     {opc[7:3], 3'b000} == `OP_CALL_REL_D ||
                                     (opc == `OP_GRP9F && rj <= `SUB_RET)) begin
                            // Delayed forms: one cycle, target held for after the slot
                            if (opc[7:4] == `OP_BRD_HI) begin
                                slot_pending_r <= cond_met(opc[3:0], PROCESSOR_STATUS); // [RULE9]
                                slot_target_r <= short_disp_tgt;
                            end else if ({opc[7:3], 3'b000} == `OP_CALL_REL_D) begin
                                RETURN_LINK <= PC + `DSLOT_LINK; // [RULE9]
                                slot_pending_r <= 1'b1;
                                slot_target_r <= long_disp_tgt;
                            end else begin
                                if (rj == `SUB_CALL)
                                    RETURN_LINK <= PC + `DSLOT_LINK;
                                slot_pending_r <= 1'b1;
                                slot_target_r <= (rj == `SUB_RET) ? RETURN_LINK : DEST_GPR_VAL;
                            end
                        end
                    end
                end
                ST_BUBBLE: begin
                    // Second cycle of a taken undelayed transfer
                    FETCH_READY <= 1'b1; // [RULE3]
                    state_r <= ST_RUN;
                end
                ST_PUSH_PS: begin
                    if (MEM_ACK) begin
                        sp_r <= sp_r - `STACK_STEP;
                        MEM_ADDR <= sp_r - `STACK_STEP;
                        MEM_WDATA <= ret_r;
                        state_r <= ST_PUSH_PC;
                    end
                end
                ST_PUSH_PC: begin
                    if (MEM_ACK) begin
                        PROCESSOR_STATUS[`PS_I] <= 1'b0; // [RULE7]
                        PROCESSOR_STATUS[`PS_S] <= 1'b0;
                        MEM_WRITE <= 1'b0;
                        MEM_ADDR <= vec_r;
                        state_r <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    if (MEM_ACK) begin
                        PC <= MEM_RDATA;
                        MEM_REQ <= 1'b0;
                        FETCH_READY <= 1'b1;
                        state_r <= ST_RUN;
                    end
                end
                ST_POP_PC: begin
                    if (MEM_ACK) begin
                        PC <= MEM_RDATA;
                        MEM_ADDR <= sp_r + `STACK_STEP;
                        state_r <= ST_POP_PS;
                    end
                end
                ST_POP_PS: begin
                    if (MEM_ACK) begin
                        PROCESSOR_STATUS <= MEM_RDATA; // [RULE8]
                        MEM_REQ <= 1'b0;
                        FETCH_READY <= 1'b1;
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end
endmodule
`default_nettype wire

/* rtl/branch_move_regs.vh */
// Constants for the branch and register-copy decoder
`ifndef BRANCH_MOVE_REGS_VH
`define BRANCH_MOVE_REGS_VH
// Primary opcodes (high byte of the instruction)
`define OP_COPY_GG 8'h8B
`define OP_COPY_SG 8'hB7
`define OP_COPY_GS 8'hB3
`define OP_GRP07 8'h07
`define OP_GRP17 8'h17
`define OP_GRP97 8'h97
`define OP_GRP9F 8'h9F
`define OP_TRAP 8'h1F
`define OP_CALL_REL 8'hD0
`define OP_CALL_REL_D 8'hD8
`define OP_BR_HI 4'hE
`define OP_BRD_HI 4'hF
// Sub-codes in the high nibble of the second byte for E-type groups
`define SUB_PS 4'h1
`define SUB_JUMP 4'h0
`define SUB_CALL 4'h1
`define SUB_RET 4'h2
`define SUB_TRAP_EXIT 4'h3
// Field positions
`define OPC_MSB 15
`define OPC_LSB 8
`define RJ_MSB 7
`define RJ_LSB 4
`define RI_MSB 3
`define RI_LSB 0
`define DISP11_MSB 10
// Address arithmetic
`define INSN_BYTES 32'h0000_0002
`define DSLOT_LINK 32'h0000_0004
`define STACK_STEP 32'h0000_0004
`define VEC_TOP 32'h0000_03FC
// Status word field positions
`define PS_C 0
`define PS_V 1
`define PS_Z 2
`define PS_N 3
`define PS_I 4
`define PS_S 5
// Cycle counts of the multi-cycle sequences
`define TAKEN_CYCLES 2'h2
// Reset values
`define PC_RESET 32'h0000_0000
`define PS_RESET 32'h0000_0000
`endif

/* test/branch_move_checker.sv */
// Port-level assertions for the branch and register-copy decoder
`timescale 1ns/1ns
`default_nettype none
module branch_move_checker (
    // Clock, reset and fetch
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [15:0] INSN,
    input wire logic INSN_VALID,
    input wire logic FETCH_READY,
    input wire logic [31:0] PC,
    // Register file
    input wire logic [31:0] SOURCE_GPR_VAL,
    input wire logic [31:0] DEST_GPR_VAL,
    input wire logic GPR_WE,
    input wire logic [3:0] GPR_WADDR,
    input wire logic [31:0] GPR_WDATA,
    input wire logic SPECIAL_WE,
    input wire logic [31:0] SPECIAL_WDATA,
    input wire logic [31:0] RETURN_LINK,
    input wire logic [31:0] PROCESSOR_STATUS,
    // Memory port
    input wire logic MEM_REQ,
    input wire logic MEM_WRITE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [31:0] MEM_WDATA,
    input wire logic [31:0] SUPERVISOR_STACK
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    wire acc = INSN_VALID && FETCH_READY;
    wire [31:0] off8 = {{23{INSN[7]}}, INSN[7:0], 1'b0};
    wire [31:0] off11 = {{20{INSN[10]}}, INSN[10:0], 1'b0};
    sequence s_take(logic [7:0] op);
        acc && INSN[15:8] == op;
    endsequence
    // A taken undelayed transfer refuses exactly one fetch slot
    sequence s_stall;
        !FETCH_READY ##1 FETCH_READY;
    endsequence
    property p_copy_gg;
        s_take(8'h8B) |=> GPR_WE && GPR_WADDR == $past(INSN[3:0])
            && GPR_WDATA == $past(SOURCE_GPR_VAL) && $stable(PROCESSOR_STATUS);
    endproperty
    a_copy_gg: assert property (p_copy_gg) else $error("gpr copy");
    property p_copy_gs;
        s_take(8'hB3) |=> SPECIAL_WE && SPECIAL_WDATA == $past(DEST_GPR_VAL);
    endproperty
    a_copy_gs: assert property (p_copy_gs) else $error("special copy");
    property p_bra;
        s_take(8'hE0) |=> PC == $past(PC) + 32'h2 + $past(off8) ##0 s_stall;
    endproperty
    a_bra: assert property (p_bra) else $error("short branch");
    property p_bno;
        s_take(8'hE1) |=> FETCH_READY && PC == $past(PC) + 32'h2;
    endproperty
    a_bno: assert property (p_bno) else $error("never branch");
    property p_call;
        acc && INSN[15:11] == 5'h1A |=> RETURN_LINK == $past(PC) + 32'h2
            && PC == $past(PC) + 32'h2 + $past(off11);
    endproperty
    a_call: assert property (p_call) else $error("call");
    property p_dcall;
        acc && INSN[15:11] == 5'h1B |=> FETCH_READY && RETURN_LINK == $past(PC) + 32'h4;
    endproperty
    a_dcall: assert property (p_dcall) else $error("delayed call");
    property p_jump;
        s_take(8'h97) ##0 INSN[7:4] == 4'h0 |=> PC == $past(DEST_GPR_VAL) ##0 s_stall;
    endproperty
    a_jump: assert property (p_jump) else $error("jump");
    property p_trap;
        s_take(8'h1F) |=> MEM_REQ && MEM_WRITE && MEM_ADDR == SUPERVISOR_STACK - 32'h4
            && MEM_WDATA == $past(PROCESSOR_STATUS);
    endproperty
    a_trap: assert property (p_trap) else $error("trap push");
endmodule
bind branch_move_decode branch_move_checker i_branch_move_checker (.CLK(CLK), .RESETN(RESETN),
    .INSN(INSN), .INSN_VALID(INSN_VALID), .FETCH_READY(FETCH_READY), .PC(PC),
    .SOURCE_GPR_VAL(SOURCE_GPR_VAL), .DEST_GPR_VAL(DEST_GPR_VAL), .GPR_WE(GPR_WE),
    .GPR_WADDR(GPR_WADDR), .GPR_WDATA(GPR_WDATA), .SPECIAL_WE(SPECIAL_WE),
    .SPECIAL_WDATA(SPECIAL_WDATA), .RETURN_LINK(RETURN_LINK), .MEM_REQ(MEM_REQ),
    .PROCESSOR_STATUS(PROCESSOR_STATUS), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .SUPERVISOR_STACK(SUPERVISOR_STACK));
`default_nettype wire

/* test/branch_move_decode_test.sv */
// Self-checking bench for the branch and register-copy decoder
`timescale 1ns/1ns
`default_nettype none
module branch_move_decode_test;
    logic CLK = 0;
    logic RESETN = 0;
    logic INSN_VALID = 0;
    logic MEM_ACK = 0;
    logic [15:0] INSN = 0;
    logic [31:0] DEST_GPR_VAL = 0;
    logic [31:0] MEM_RDATA = 0;
    wire [31:0] SOURCE_GPR_VAL = 32'h1111_2222;
    wire [31:0] SPECIAL_REG_VAL = 32'h3333_4444;
    wire [31:0] SUPERVISOR_STACK = 32'h0000_2008;
    wire [31:0] VECTOR_BASE = 32'h0001_0000;
    wire FETCH_READY, GPR_WE, SPECIAL_WE, MEM_REQ, MEM_WRITE;
    wire [3:0] GPR_WADDR, SPECIAL_WADDR;
    wire [31:0] PC, GPR_WDATA, SPECIAL_WDATA, RETURN_LINK, PROCESSOR_STATUS, MEM_ADDR, MEM_WDATA;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] pc0;
    logic [63:0] wq[$];
    branch_move_decode i_branch_move_decode (
        .CLK(CLK), .RESETN(RESETN), .INSN(INSN), .INSN_VALID(INSN_VALID),
        .FETCH_READY(FETCH_READY), .PC(PC), .SOURCE_GPR_VAL(SOURCE_GPR_VAL),
        .DEST_GPR_VAL(DEST_GPR_VAL), .SPECIAL_REG_VAL(SPECIAL_REG_VAL),
        .GPR_WE(GPR_WE), .GPR_WADDR(GPR_WADDR), .GPR_WDATA(GPR_WDATA),
        .SPECIAL_WE(SPECIAL_WE), .SPECIAL_WADDR(SPECIAL_WADDR), .SPECIAL_WDATA(SPECIAL_WDATA),
        .RETURN_LINK(RETURN_LINK), .PROCESSOR_STATUS(PROCESSOR_STATUS),
        .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
        .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .SUPERVISOR_STACK(SUPERVISOR_STACK),
        .VECTOR_BASE(VECTOR_BASE)
    );
    always #4 CLK = ~CLK;
    // ------------------------------------------------------------
    // Memory: acks every second cycle so each beat is held a while
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        MEM_ACK <= MEM_REQ && !MEM_ACK;
        MEM_RDATA <= MEM_ADDR + 32'h0000_0100;
        if (MEM_REQ && MEM_ACK && MEM_WRITE) begin
            wq.push_back({MEM_ADDR, MEM_WDATA});
        end
    end
    task automatic chk(string nm, logic [63:0] got, logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Waits for a free fetch slot, then hands over one word
    task automatic issue(logic [15:0] w, logic [31:0] d);
        int n;
        n = 0;
        @(negedge CLK);
        while (FETCH_READY !== 1'b1 && n < 40) begin
            n++;
            @(negedge CLK);
        end
        // A fetch slot that never opens counts against the run
        if (n >= 40) err_total++;
        pc0 = PC;
        @(posedge CLK);
        INSN <= w;
        DEST_GPR_VAL <= d;
        INSN_VALID <= 1'b1;
        @(posedge CLK);
        INSN_VALID <= 1'b0;
        @(negedge CLK);
    endtask
    function automatic logic cond(logic [3:0] c, logic [3:0] f);
        logic r;
        case (c[3:1])
            3'd0: r = 1'b1;
            3'd1: r = f[2];
            3'd2: r = f[0];
            3'd3: r = f[3];
            3'd4: r = f[1];
            3'd5: r = f[1] ^ f[3];
            3'd6: r = (f[1] ^ f[3]) | f[2];
            default: r = f[0] | f[2];
        endcase
        return c[0] ? !r : r;
    endfunction
    task automatic t_copies();
        issue(16'h0712, 32'h0000_000A);
        chk("ps", PROCESSOR_STATUS, 32'h0000_000A);
        issue(16'h8B53, 0);
        chk("gg", {GPR_WE, GPR_WADDR, GPR_WDATA}, {1'b1, 4'h3, SOURCE_GPR_VAL});
        chk("gg ps", PROCESSOR_STATUS, 32'h0000_000A);
        issue(16'hB754, 0);
        chk("sg", {GPR_WE, GPR_WADDR, GPR_WDATA}, {1'b1, 4'h4, SPECIAL_REG_VAL});
        issue(16'hB356, 32'hCAFE_0001);
        chk("gs", {SPECIAL_WE, SPECIAL_WADDR, SPECIAL_WDATA}, {1'b1, 4'h5, 32'hCAFE_0001});
        issue(16'h1717, 0);
        chk("psg", {GPR_WE, GPR_WADDR, GPR_WDATA}, {1'b1, 4'h7, 32'h0000_000A});
    endtask
    task automatic t_branches();
        logic [31:0] tgt;
        logic tk;
        for (int f = 0; f < 16; f++) begin
            issue(16'h0712, 32'(f));
            for (int c = 0; c < 16; c++) begin
                tk = cond(c[3:0], f[3:0]);
                for (int d = 0; d < 2; d++) begin
                    issue({3'b111, d[0], c[3:0], f[3:0], c[3:0]}, 32'(f));
                    tgt = pc0 + {{23{f[3]}}, f[3:0], c[3:0], 1'b0} + 32'h2;
                    if (d == 1) begin
                        chk("dbr ready", FETCH_READY, 1'b1);
                        issue(16'h8B53, 32'(f)); // A one-cycle copy fills the slot
                        chk("slot", GPR_WE, 1'b1);
                    end else begin
                        chk("br ready", FETCH_READY, !tk);
                    end
                    chk("br pc", PC, tk ? tgt : pc0 + 32'h2);
                end
            end
        end
    endtask
    task automatic t_calls();
        logic [31:0] lnk;
        issue(16'hD47F, 0);
        chk("call", {RETURN_LINK, PC}, {pc0 + 32'h2, pc0 + 32'hFFFF_F900});
        issue(16'hD810, 0);
        lnk = pc0 + 32'h4;
        chk("dcall link", RETURN_LINK, lnk);
        issue(16'h8B53, 0);
        chk("dcall pc", PC, pc0 + 32'h20);
        issue(16'h9702, 32'h0000_4000);
        chk("jump", {FETCH_READY, PC}, {1'b0, 32'h0000_4000});
        issue(16'h9720, 0);
        chk("exit", {FETCH_READY, PC}, {1'b0, lnk});
        issue(16'h9712, 32'h0000_5000);
        chk("call reg", {RETURN_LINK, PC}, {pc0 + 32'h2, 32'h0000_5000});
        issue(16'h9F13, 32'h0000_6000);
        lnk = pc0 + 32'h4;
        chk("dcall reg", {FETCH_READY, RETURN_LINK}, {1'b1, lnk});
        issue(16'h8B53, 0);
        chk("dcall reg pc", PC, 32'h0000_6000);
        issue(16'h9F20, 0);
        chk("dret ready", FETCH_READY, 1'b1);
        issue(16'h8B53, 0);
        chk("dret pc", PC, lnk);
        issue(16'h9F04, 32'h0000_7000);
        issue(16'h8B53, 0);
        chk("djump pc", PC, 32'h0000_7000);
    endtask
    task automatic t_trap();
        logic [31:0] ret;
        issue(16'h0712, 32'h0000_003F);
        wq.delete();
        issue(16'h1F05, 0);
        ret = pc0 + 32'h2;
        issue(16'h8B53, 0);
        chk("vector", pc0, VECTOR_BASE + 32'h3FC - 32'h14 + 32'h100);
        chk("trap ps", PROCESSOR_STATUS[5:0], 6'h0F);
        chk("push n", wq.size(), 2);
        chk("push", wq[0], {SUPERVISOR_STACK - 32'h4, 32'h0000_003F});
        chk("push pc", wq[1], {SUPERVISOR_STACK - 32'h8, ret});
        // Status flag S is clear here, as the trap exit requires
        issue(16'h9730, 0);
        issue(16'h8B53, 0);
        chk("exit pc", pc0, SUPERVISOR_STACK + 32'h100);
        chk("exit ps", PROCESSOR_STATUS[3:0], 4'hC);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        t_copies();
        t_branches();
        t_calls();
        t_trap();
        report_and_stop();
    end
    // Full run is near 20 us; ten times that means a hang
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
